//--- include/pdc_pkg.sv
// shared constants and types for the peripheral dma channel
package pdc_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_RX_PTR = 12'h100;
  localparam logic [11:0] OFS_RX_CNT = 12'h104;
  localparam logic [11:0] OFS_TX_PTR = 12'h108;
  localparam logic [11:0] OFS_TX_CNT = 12'h10c;
  localparam logic [11:0] OFS_RX_NPTR = 12'h110;
  localparam logic [11:0] OFS_RX_NCNT = 12'h114;
  localparam logic [11:0] OFS_TX_NPTR = 12'h118;
  localparam logic [11:0] OFS_TX_NCNT = 12'h11c;
  localparam logic [11:0] OFS_CTRL = 12'h120;
  localparam logic [11:0] OFS_STAT = 12'h124;
  // control and status bit positions
  localparam int BIT_RX_EN = 0;
  localparam int BIT_RX_DIS = 1;
  localparam int BIT_TX_EN = 8;
  localparam int BIT_TX_DIS = 9;
  // counter and pointer widths, reset values
  localparam int CNT_W = 16;
  localparam int PTR_W = 32;
  localparam logic [31:0] RST_PTR = 32'h0000_0000;
  localparam logic [15:0] RST_CNT = 16'h0000;
  // unit size codes and pointer increments
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [31:0] INC_BYTE = 32'h0000_0001;
  localparam logic [31:0] INC_HALF = 32'h0000_0002;
  localparam logic [31:0] INC_WORD = 32'h0000_0004;
  // memory request carried to the bus matrix
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pdc_mem_req_type;
  // transfer engine states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RX_MEM,
    ST_TX_MEM
  } pdc_state_type;
endpackage

//--- logic/pdc_chan.sv
// one dma channel: current and following address and size
`timescale 1ns/1ps
module pdc_chan (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // software writes
  input wire logic wr_cur_ptr_i,
  input wire logic wr_cur_cnt_i,
  input wire logic wr_nxt_ptr_i,
  input wire logic wr_nxt_cnt_i,
  input wire logic [31:0] wr_val_i,
  // one unit moved
  input wire logic step_i,
  input wire logic [31:0] inc_i,
  // state
  output logic [31:0] cur_ptr_o,
  output logic [15:0] cur_cnt_o,
  output logic [31:0] nxt_ptr_o,
  output logic [15:0] nxt_cnt_o
);
  logic [31:0] cur_ptr_r, cur_ptr_nxt, nxt_ptr_r, nxt_ptr_nxt;
  logic [15:0] cur_cnt_r, cur_cnt_nxt, nxt_cnt_r, nxt_cnt_nxt;

  // advance, reload from the following pair, then software writes win
  always_comb begin
    cur_ptr_nxt = cur_ptr_r;
    cur_cnt_nxt = cur_cnt_r;
    nxt_ptr_nxt = nxt_ptr_r;
    nxt_cnt_nxt = nxt_cnt_r;
    if (step_i && cur_cnt_r != pdc_pkg::RST_CNT) begin
      cur_ptr_nxt = cur_ptr_r + inc_i;
      cur_cnt_nxt = cur_cnt_r - 16'h0001;
    end
    if (cur_cnt_nxt == pdc_pkg::RST_CNT && nxt_cnt_r != pdc_pkg::RST_CNT) begin
      cur_ptr_nxt = nxt_ptr_r;
      cur_cnt_nxt = nxt_cnt_r;
      nxt_ptr_nxt = pdc_pkg::RST_PTR;
      nxt_cnt_nxt = pdc_pkg::RST_CNT;
    end
    if (wr_cur_ptr_i) cur_ptr_nxt = wr_val_i;
    if (wr_cur_cnt_i) cur_cnt_nxt = wr_val_i[15:0];
    if (wr_nxt_ptr_i) nxt_ptr_nxt = wr_val_i;
    if (wr_nxt_cnt_i) nxt_cnt_nxt = wr_val_i[15:0];
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_ptr_r <= pdc_pkg::RST_PTR;
      cur_cnt_r <= pdc_pkg::RST_CNT;
      nxt_ptr_r <= pdc_pkg::RST_PTR;
      nxt_cnt_r <= pdc_pkg::RST_CNT;
    end else begin
      cur_ptr_r <= cur_ptr_nxt;
      cur_cnt_r <= cur_cnt_nxt;
      nxt_ptr_r <= nxt_ptr_nxt;
      nxt_cnt_r <= nxt_cnt_nxt;
    end
  end

  assign cur_ptr_o = cur_ptr_r;
  assign cur_cnt_o = cur_cnt_r;
  assign nxt_ptr_o = nxt_ptr_r;
  assign nxt_cnt_o = nxt_cnt_r;
endmodule // pdc_chan

//--- logic/pdc_top.sv
// peripheral dma channel pair with wishbone register access
`timescale 1ns/1ps
// Overview of operation
// - half duplex shares one current address
// - zero transmit size moves no data
// - nonzero size starts transfers when enabled
// - receive following address register
// - receive following 16-bit size register
// - transmit following address register
// - transmit following 16-bit size register
// - half duplex shares one current size
// - half duplex shares one following address
// - half duplex shares one following size
// - bit 0 enables receive, zero ignored
// - bit 1 disables receive, wins over enable
// - bit 8 enables transmit requests
// - bit 9 disables transmit requests
// - half duplex receive enable stops transmit
// - half duplex transmit enable needs no receive
// - half duplex receive disable stops transmit
// - half duplex transmit disable stops receive
// - status shows enables in bits 0, 8
// - empty current reloads from following pair
// - address advances by 1, 2, 4
// - done and all-buffers flags from sizes
module pdc_top #(
  parameter bit HALF_DUPLEX = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // peripheral receive side
  input wire logic rx_ready_i,
  input wire logic [31:0] rx_data_i,
  output logic rx_take_o,
  // peripheral transmit side
  input wire logic tx_ready_i,
  output logic [31:0] tx_data_o,
  output logic tx_write_o,
  // unit size of the peripheral
  input wire logic [1:0] unit_size_i,
  // memory master
  output pdc_pkg::pdc_mem_req_type mem_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // flags to the peripheral
  output logic rx_current_done_o,
  output logic rx_all_buffers_full_o,
  output logic tx_current_done_o,
  output logic tx_all_buffers_empty_o
);
  localparam int NCH = HALF_DUPLEX ? 1 : 2;
  localparam int TX_CH = HALF_DUPLEX ? 0 : 1;

  logic [31:0] cur_ptr [2];
  logic [15:0] cur_cnt [2];
  logic [31:0] nxt_ptr [2];
  logic [15:0] nxt_cnt [2];
  logic [1:0] wr_cp, wr_cc, wr_np, wr_nc, step;
  logic [31:0] rd_val, wr_val, inc;
  logic wr_go, rd_go;

  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic rx_en_r, rx_en_nxt, tx_en_r, tx_en_nxt;
  pdc_pkg::pdc_state_type st_r, st_nxt;
  pdc_pkg::pdc_mem_req_type mem_r, mem_nxt;
  logic rx_take_r, rx_take_nxt, tx_write_r, tx_write_nxt;
  logic [31:0] tx_data_r, tx_data_nxt;
  logic rx_step, tx_step;
  logic rxd_r, rxd_nxt, rxf_r, rxf_nxt, txd_r, txd_nxt, txe_r, txe_nxt;

  // byte lane merge for partial writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  // one access per classic cycle, ack gap keeps it single
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
  assign rd_go = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;

  // register read view; half duplex aliases both names to one channel
  always_comb begin
    rd_val = 32'h0000_0000;
    case (wb_adr_i)
      pdc_pkg::OFS_RX_PTR: rd_val = cur_ptr[0];
      pdc_pkg::OFS_RX_CNT: rd_val = {16'h0000, cur_cnt[0]};
      pdc_pkg::OFS_TX_PTR: rd_val = cur_ptr[TX_CH];
      pdc_pkg::OFS_TX_CNT: rd_val = {16'h0000, cur_cnt[TX_CH]};
      pdc_pkg::OFS_RX_NPTR: rd_val = nxt_ptr[0];
      pdc_pkg::OFS_RX_NCNT: rd_val = {16'h0000, nxt_cnt[0]};
      pdc_pkg::OFS_TX_NPTR: rd_val = nxt_ptr[TX_CH];
      pdc_pkg::OFS_TX_NCNT: rd_val = {16'h0000, nxt_cnt[TX_CH]};
      pdc_pkg::OFS_STAT: begin
        rd_val[pdc_pkg::BIT_RX_EN] = rx_en_r;
        rd_val[pdc_pkg::BIT_TX_EN] = tx_en_r;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  assign wr_val = lane_merge(rd_val, wb_dat_i, wb_sel_i);

  // write strobes per channel
  always_comb begin
    wr_cp = 2'h0;
    wr_cc = 2'h0;
    wr_np = 2'h0;
    wr_nc = 2'h0;
    if (wr_go) begin
      case (wb_adr_i)
        pdc_pkg::OFS_RX_PTR: wr_cp[0] = 1'b1;
        pdc_pkg::OFS_RX_CNT: wr_cc[0] = 1'b1;
        pdc_pkg::OFS_TX_PTR: wr_cp[TX_CH] = 1'b1;
        pdc_pkg::OFS_TX_CNT: wr_cc[TX_CH] = 1'b1;
        pdc_pkg::OFS_RX_NPTR: wr_np[0] = 1'b1;
        pdc_pkg::OFS_RX_NCNT: wr_nc[0] = 1'b1;
        pdc_pkg::OFS_TX_NPTR: wr_np[TX_CH] = 1'b1;
        pdc_pkg::OFS_TX_NCNT: wr_nc[TX_CH] = 1'b1;
        default: wr_cp = 2'h0;
      endcase
    end
  end

  // wishbone answer, one cycle after the request
  always_comb begin
    ack_nxt = 1'b0;
    dat_nxt = dat_r;
    if (wr_go || rd_go) begin
      ack_nxt = 1'b1;
      dat_nxt = rd_go ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // channel request enables from the control register
  always_comb begin
    logic en_rx, dis_rx, en_tx, dis_tx;
    en_rx = 1'b0;
    dis_rx = 1'b0;
    en_tx = 1'b0;
    dis_tx = 1'b0;
    rx_en_nxt = rx_en_r;
    tx_en_nxt = tx_en_r;
    if (wr_go && wb_adr_i == pdc_pkg::OFS_CTRL) begin
      en_rx = wr_val[pdc_pkg::BIT_RX_EN];
      dis_rx = wr_val[pdc_pkg::BIT_RX_DIS];
      en_tx = wr_val[pdc_pkg::BIT_TX_EN];
      dis_tx = wr_val[pdc_pkg::BIT_TX_DIS];
    end
    if (HALF_DUPLEX) begin
      if (dis_rx || dis_tx) begin
        rx_en_nxt = 1'b0;
        tx_en_nxt = 1'b0;
      end else if (en_rx) begin
        rx_en_nxt = 1'b1;
        tx_en_nxt = 1'b0;
      end else if (en_tx) begin
        tx_en_nxt = 1'b1;
        rx_en_nxt = 1'b0;
      end
    end else begin
      if (dis_rx) rx_en_nxt = 1'b0;
      else if (en_rx) rx_en_nxt = 1'b1;
      if (dis_tx) tx_en_nxt = 1'b0;
      else if (en_tx) tx_en_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
    end else begin
      rx_en_r <= rx_en_nxt;
      tx_en_r <= tx_en_nxt;
    end
  end

  // pointer increment for the unit size
  always_comb begin
    case (unit_size_i)
      pdc_pkg::SIZE_BYTE: inc = pdc_pkg::INC_BYTE;
      pdc_pkg::SIZE_HALF: inc = pdc_pkg::INC_HALF;
      pdc_pkg::SIZE_WORD: inc = pdc_pkg::INC_WORD;
      default: inc = pdc_pkg::INC_WORD;
    endcase
  end

  // step strobes, shared channel in half duplex
  always_comb begin
    step = 2'h0;
    step[0] = rx_step;
    step[TX_CH] = step[TX_CH] | tx_step;
  end

  // channel storage
  for (genvar c = 0; c < 2; c++) begin : g_ch
    if (c < NCH) begin : g_on
      pdc_chan u_chan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_cur_ptr_i(wr_cp[c]),
        .wr_cur_cnt_i(wr_cc[c]),
        .wr_nxt_ptr_i(wr_np[c]),
        .wr_nxt_cnt_i(wr_nc[c]),
        .wr_val_i(wr_val),
        .step_i(step[c]),
        .inc_i(inc),
        .cur_ptr_o(cur_ptr[c]),
        .cur_cnt_o(cur_cnt[c]),
        .nxt_ptr_o(nxt_ptr[c]),
        .nxt_cnt_o(nxt_cnt[c])
      );
    end else begin : g_off
      assign cur_ptr[c] = pdc_pkg::RST_PTR;
      assign cur_cnt[c] = pdc_pkg::RST_CNT;
      assign nxt_ptr[c] = pdc_pkg::RST_PTR;
      assign nxt_cnt[c] = pdc_pkg::RST_CNT;
    end
  end

  // transfer engine: receive before transmit, one unit at a time
  always_comb begin
    st_nxt = st_r;
    mem_nxt = mem_r;
    rx_take_nxt = 1'b0;
    tx_write_nxt = 1'b0;
    tx_data_nxt = tx_data_r;
    rx_step = 1'b0;
    tx_step = 1'b0;
    case (st_r)
      pdc_pkg::ST_IDLE: begin
        if (rx_en_r && rx_ready_i && cur_cnt[0] != pdc_pkg::RST_CNT) begin
          mem_nxt.req = 1'b1;
          mem_nxt.we = 1'b1;
          mem_nxt.size = unit_size_i;
          mem_nxt.addr = cur_ptr[0];
          mem_nxt.wdata = rx_data_i;
          rx_take_nxt = 1'b1;
          st_nxt = pdc_pkg::ST_RX_MEM;
        end else if (tx_en_r && tx_ready_i &&
                     cur_cnt[TX_CH] != pdc_pkg::RST_CNT) begin
          mem_nxt.req = 1'b1;
          mem_nxt.we = 1'b0;
          mem_nxt.size = unit_size_i;
          mem_nxt.addr = cur_ptr[TX_CH];
          mem_nxt.wdata = 32'h0000_0000;
          st_nxt = pdc_pkg::ST_TX_MEM;
        end
      end
      pdc_pkg::ST_RX_MEM: begin
        if (mem_ack_i) begin
          mem_nxt.req = 1'b0;
          rx_step = 1'b1;
          st_nxt = pdc_pkg::ST_IDLE;
        end
      end
      pdc_pkg::ST_TX_MEM: begin
        if (mem_ack_i) begin
          mem_nxt.req = 1'b0;
          tx_data_nxt = mem_rdata_i;
          tx_write_nxt = 1'b1;
          tx_step = 1'b1;
          st_nxt = pdc_pkg::ST_IDLE;
        end
      end
      default: st_nxt = pdc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= pdc_pkg::ST_IDLE;
      mem_r <= '0;
      rx_take_r <= 1'b0;
      tx_write_r <= 1'b0;
      tx_data_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      mem_r <= mem_nxt;
      rx_take_r <= rx_take_nxt;
      tx_write_r <= tx_write_nxt;
      tx_data_r <= tx_data_nxt;
    end
  end

  // end and buffer flags follow the size registers
  always_comb begin
    rxd_nxt = cur_cnt[0] == pdc_pkg::RST_CNT;
    rxf_nxt = rxd_nxt && nxt_cnt[0] == pdc_pkg::RST_CNT;
    txd_nxt = cur_cnt[TX_CH] == pdc_pkg::RST_CNT;
    txe_nxt = txd_nxt && nxt_cnt[TX_CH] == pdc_pkg::RST_CNT;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_r <= 1'b1;
      rxf_r <= 1'b1;
      txd_r <= 1'b1;
      txe_r <= 1'b1;
    end else begin
      rxd_r <= rxd_nxt;
      rxf_r <= rxf_nxt;
      txd_r <= txd_nxt;
      txe_r <= txe_nxt;
    end
  end

  // outputs
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign mem_o = mem_r;
  assign rx_take_o = rx_take_r;
  assign tx_write_o = tx_write_r;
  assign tx_data_o = tx_data_r;
  assign rx_current_done_o = rxd_r;
  assign rx_all_buffers_full_o = rxf_r;
  assign tx_current_done_o = txd_r;
  assign tx_all_buffers_empty_o = txe_r;
endmodule // pdc_top

//--- tb/pdc_far_model.sv
// far side model: receive source of the peripheral and memory slave
`timescale 1ns/1ps
module pdc_far_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // engine side
  input wire pdc_pkg::pdc_mem_req_type mem_i,
  input wire logic rx_take_i,
  // bench controls
  input wire logic rx_want_i,
  input wire logic slow_i,
  // answers
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o,
  output logic rx_ready_o,
  output logic [31:0] rx_data_o
);
  logic [3:0] wait_r;
  logic [15:0] unit_r;
  logic [31:0] tick_r;
  // memory ack after 0 or 3 wait cycles, receive ready drops after each take
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_r <= 4'h0;
      mem_ack_o <= 1'b0;
      rx_ready_o <= 1'b0;
      unit_r <= 16'h0;
      tick_r <= 32'h0;
    end else begin
      mem_ack_o <= mem_i.req && !mem_ack_o && wait_r >= (slow_i ? 4'h3 : 4'h0);
      wait_r <= (mem_i.req && !mem_ack_o) ? wait_r + 4'h1 : 4'h0;
      rx_ready_o <= rx_want_i && !rx_take_i;
      unit_r <= unit_r + {15'h0, rx_take_i};
      tick_r <= tick_r + 32'h1;
    end
  end
  // idle buses show moving or inverted values, never the last good one
  assign mem_rdata_o = mem_ack_o ? (mem_i.addr ^ 32'h5a5a_0000) : tick_r;
  assign rx_data_o = rx_ready_o ? {16'hc0de, unit_r} : ~{16'hc0de, unit_r};
endmodule // pdc_far_model

//--- tb/pdc_top_chk.sv
// port assertions for the dma channel pair
`timescale 1ns/1ps
module pdc_top_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // memory and peripheral
  input wire pdc_pkg::pdc_mem_req_type mem_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic rx_take_o,
  input wire logic tx_write_o,
  input wire logic [31:0] tx_data_o,
  // flags
  input wire logic rx_current_done_o,
  input wire logic rx_all_buffers_full_o,
  input wire logic tx_current_done_o,
  input wire logic tx_all_buffers_empty_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // memory read for the transmitter completes
  sequence s_tx_ack;
    mem_o.req && !mem_o.we && mem_ack_i;
  endsequence
  // fetched unit handed to the peripheral
  sequence s_tx_put;
    tx_write_o && tx_data_o == $past(mem_rdata_i);
  endsequence
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  AST_TX_DATA: assert property (s_tx_ack |=> s_tx_put)
    else $error("tx unit not passed on");
  AST_REQ_HOLD: assert property (mem_o.req && !mem_ack_i |=> mem_o.req && $stable(mem_o))
    else $error("memory request moved");
  AST_REQ_DROP: assert property (mem_o.req && mem_ack_i |=> !mem_o.req)
    else $error("memory request kept");
  AST_RX_TAKE: assert property (rx_take_o |-> mem_o.req && mem_o.we)
    else $error("rx take without write");
  AST_TX_ZERO: assert property ($rose(mem_o.req) && !mem_o.we |-> !tx_current_done_o)
    else $error("tx moved with zero size");
  AST_FLAG_TX: assert property (tx_all_buffers_empty_o |-> tx_current_done_o)
    else $error("tx flags disagree");
  AST_FLAG_RX: assert property (rx_all_buffers_full_o |-> rx_current_done_o)
    else $error("rx flags disagree");
endmodule // pdc_top_chk

bind pdc_top pdc_top_chk i_pdc_top_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_o(mem_o), .mem_ack_i(mem_ack_i),
  .mem_rdata_i(mem_rdata_i), .rx_take_o(rx_take_o), .tx_write_o(tx_write_o),
  .tx_data_o(tx_data_o), .rx_current_done_o(rx_current_done_o),
  .rx_all_buffers_full_o(rx_all_buffers_full_o), .tx_current_done_o(tx_current_done_o),
  .tx_all_buffers_empty_o(tx_all_buffers_empty_o));

//--- tb/pdc_top_test.sv
// self-checking bench for the dma channel pair
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module pdc_top_test;
  typedef struct packed {
    logic [11:0] wa;
    logic [31:0] d;
    logic [3:0] s;
    logic [11:0] ra;
    logic [31:0] e;
  } pdc_row_type;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tx_rdy = 1'b0, rx_want = 1'b0, slow = 1'b0;
  logic [11:0] adr = 12'h0;
  logic [3:0] sel = 4'h0;
  logic [1:0] usz = 2'h0;
  logic [31:0] dat = 32'h0, q, hq, inc;
  wire [31:0] rdat, hrdat, rx_dat, tx_dat, mrd;
  wire ack, hack, rx_rdy, take, txw, mack;
  wire [3:0] fl;
  pdc_pkg::pdc_mem_req_type mem;
  logic [31:0] ma[$], mw[$], tq[$];
  int err_total = 0;
  int checks = 0;
  // write, then read back: ra holds e afterwards
  pdc_row_type rows [13] = '{
    '{pdc_pkg::OFS_TX_PTR, 32'h1234_5678, 4'hf, pdc_pkg::OFS_TX_PTR, 32'h1234_5678},
    '{pdc_pkg::OFS_TX_PTR, 32'haaaa_bbbb, 4'h3, pdc_pkg::OFS_TX_PTR, 32'h1234_bbbb},
    '{pdc_pkg::OFS_TX_CNT, 32'hffff_1234, 4'hf, pdc_pkg::OFS_TX_CNT, 32'h0000_1234},
    '{pdc_pkg::OFS_RX_NPTR, 32'h0bad_f00d, 4'hf, pdc_pkg::OFS_RX_NPTR, 32'h0bad_f00d},
    '{pdc_pkg::OFS_RX_NCNT, 32'h0001_8001, 4'hf, pdc_pkg::OFS_RX_CNT, 32'h0000_8001},
    '{pdc_pkg::OFS_TX_NPTR, 32'h1357_9bdf, 4'hf, pdc_pkg::OFS_TX_NPTR, 32'h1357_9bdf},
    '{pdc_pkg::OFS_TX_NCNT, 32'hffff_ffff, 4'hf, pdc_pkg::OFS_TX_NCNT, 32'h0000_ffff},
    '{12'h128, 32'hffff_ffff, 4'hf, 12'h128, 32'h0},
    '{pdc_pkg::OFS_CTRL, 32'h0000_0101, 4'hf, pdc_pkg::OFS_STAT, 32'h0000_0101},
    '{pdc_pkg::OFS_CTRL, 32'h0000_0000, 4'hf, pdc_pkg::OFS_STAT, 32'h0000_0101},
    '{pdc_pkg::OFS_CTRL, 32'h0000_0003, 4'hf, pdc_pkg::OFS_STAT, 32'h0000_0100},
    '{pdc_pkg::OFS_CTRL, 32'h0000_0200, 4'hf, pdc_pkg::OFS_CTRL, 32'h0},
    '{12'h128, 32'h0, 4'hf, pdc_pkg::OFS_STAT, 32'h0}};
  logic [31:0] ta [3] = '{32'h1000, 32'h1004, 32'h2000};
  // half duplex control pairs and the status they leave
  logic [31:0] hc [4][3] = '{'{32'h1, 32'h100, 32'h100}, '{32'h100, 32'h1, 32'h1},
    '{32'h100, 32'h2, 32'h0}, '{32'h1, 32'h200, 32'h0}};
  // design under test and its far side
  pdc_top i_pdc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_ready_i(rx_rdy), .rx_data_i(rx_dat), .rx_take_o(take),
    .tx_ready_i(tx_rdy), .tx_data_o(tx_dat), .tx_write_o(txw), .unit_size_i(usz),
    .mem_o(mem), .mem_ack_i(mack), .mem_rdata_i(mrd), .rx_current_done_o(fl[3]),
    .rx_all_buffers_full_o(fl[2]), .tx_current_done_o(fl[1]),
    .tx_all_buffers_empty_o(fl[0]));
  // half duplex copy on the same bus, register side only
  pdc_top #(.HALF_DUPLEX(1'b1)) i_pdc_top_hd (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(hrdat), .wb_ack_o(hack), .rx_ready_i(1'b0), .rx_data_i(32'h0),
    .rx_take_o(), .tx_ready_i(1'b0), .tx_data_o(), .tx_write_o(), .unit_size_i(usz),
    .mem_o(), .mem_ack_i(1'b0), .mem_rdata_i(32'h0), .rx_current_done_o(),
    .rx_all_buffers_full_o(), .tx_current_done_o(), .tx_all_buffers_empty_o());
  pdc_far_model i_pdc_far_model (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem),
    .rx_take_i(take), .rx_want_i(rx_want), .slow_i(slow), .mem_ack_o(mack),
    .mem_rdata_o(mrd), .rx_ready_o(rx_rdy), .rx_data_o(rx_dat));
  // 200 MHz clock
  initial forever #2.5 clk_i = ~clk_i;
  // log finished memory accesses and units handed to the transmitter
  always @(posedge clk_i) begin
    if (mack && mem.req) begin
      ma.push_back(mem.addr);
      mw.push_back(mem.wdata);
    end
    if (txw) tq.push_back(tx_dat);
  end
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rst_pulse;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    hq = hrdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    `CHK(q, e)
  endtask
  task automatic hrd(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    `CHK(hq, e)
  endtask
  task automatic waitq(input int n);
    int k;
    k = 0;
    while (ma.size() < n && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    repeat (8) @(posedge clk_i);
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    results();
  end
  initial begin
    rst_pulse();
    foreach (rows[i]) begin
      wb(1'b1, rows[i].wa, rows[i].d, rows[i].s);
      rd(rows[i].ra, rows[i].e);
    end
    // mid-run reset clears every register
    rst_pulse();
    for (int a = 0; a < 10; a++) rd(12'h100 + 12'(a * 4), 32'h0);
    `CHK(fl, 4'hf)
    // transmit two words, then a one-word following buffer, slow memory
    usz <= pdc_pkg::SIZE_WORD;
    slow <= 1'b1;
    wb(1'b1, pdc_pkg::OFS_TX_PTR, 32'h1000, 4'hf);
    wb(1'b1, pdc_pkg::OFS_TX_CNT, 32'h2, 4'hf);
    wb(1'b1, pdc_pkg::OFS_TX_NPTR, 32'h2000, 4'hf);
    wb(1'b1, pdc_pkg::OFS_TX_NCNT, 32'h1, 4'hf);
    wb(1'b1, pdc_pkg::OFS_CTRL, 32'h100, 4'hf);
    tx_rdy <= 1'b1;
    waitq(3);
    `CHK(32'(tq.size()), 32'h3)
    for (int i = 0; i < 3; i++) begin
      `CHK(ma[i], ta[i])
      `CHK(tq[i], ta[i] ^ 32'h5a5a_0000)
    end
    rd(pdc_pkg::OFS_TX_PTR, 32'h2004);
    rd(pdc_pkg::OFS_TX_NCNT, 32'h0);
    `CHK(fl[1:0], 2'h3)
    tx_rdy <= 1'b0;
    slow <= 1'b0;
    // receive two units for every unit size code
    for (int s = 0; s < 4; s++) begin
      ma.delete();
      mw.delete();
      usz <= 2'(s);
      inc = (s == 0) ? 32'h1 : (s == 1) ? 32'h2 : 32'h4;
      wb(1'b1, pdc_pkg::OFS_RX_PTR, 32'h3000, 4'hf);
      wb(1'b1, pdc_pkg::OFS_RX_CNT, 32'h2, 4'hf);
      wb(1'b1, pdc_pkg::OFS_CTRL, 32'h1, 4'hf);
      rx_want <= 1'b1;
      waitq(2);
      `CHK(ma[1], 32'h3000 + inc)
      `CHK(mw[1], {16'hc0de, 16'(2 * s + 1)})
      rd(pdc_pkg::OFS_RX_PTR, 32'h3000 + 2 * inc);
      `CHK(fl[3:2], 2'h3)
      `CHK(mem.size, 2'(s))
    end
    // half duplex copy: both names reach one store, enables exclude each other
    rx_want <= 1'b0;
    wb(1'b1, pdc_pkg::OFS_TX_PTR, 32'h4444_0000, 4'hf);
    hrd(pdc_pkg::OFS_RX_PTR, 32'h4444_0000);
    wb(1'b1, pdc_pkg::OFS_RX_CNT, 32'h5, 4'hf);
    hrd(pdc_pkg::OFS_TX_CNT, 32'h5);
    wb(1'b1, pdc_pkg::OFS_TX_NPTR, 32'h5555_0000, 4'hf);
    hrd(pdc_pkg::OFS_RX_NPTR, 32'h5555_0000);
    wb(1'b1, pdc_pkg::OFS_RX_NCNT, 32'h7, 4'hf);
    hrd(pdc_pkg::OFS_TX_NCNT, 32'h7);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, pdc_pkg::OFS_CTRL, hc[i][0], 4'hf);
      wb(1'b1, pdc_pkg::OFS_CTRL, hc[i][1], 4'hf);
      hrd(pdc_pkg::OFS_STAT, hc[i][2]);
    end
    results();
  end
endmodule // pdc_top_test
